// File: design/tbcpp_timer.v
// How it works
// - Buffered compare match drives pin and loads C into A together.
// - Buffered capture stores counter in A and old A in C together.
// - Channels 1/2 and 4/5 join into 32-bit counters, upper first.
// - Upper counter counts on lower overflow/underflow when cascade clock selected.
// - Lower counter underflows only in phase counting mode.
// - Upper in phase counting mode ignores cascade clock selection.
// - Simultaneous captures store upper half in upper A, lower in lower A.
// - Cascaded upper increments on lower overflow, decrements on lower underflow.
// - PWM matches set pin low/high/toggle; clear-selected register sets period.
// - PWM mode 1 pairs A/B onto pin A and C/D onto pin C.
// - PWM mode 1 pin starts at level configured for A or C.
// - PWM mode 1 pair with equal values leaves pin unchanged.
// - PWM mode 1 gives up to eight phases, one per pair.
// - PWM mode 2: cycle match clear returns all pins to initial level.
// - PWM mode 2 duty equal to cycle leaves pin unchanged.
// - PWM mode 2 period register pin gives no output; ten phases.
// - Phase counting only on channels 1, 2, 4 and 5.
// - Phase counting ignores prescaler and edge selection.
// - Clear, I/O, enables, capture and compare still work in phase mode.
// - Phase mode sets overflow flag counting up, underflow flag counting down.
// - Status shows readable count direction flag.
// - Channels 1/5 use ext clocks A/B; channels 2/4 use C/D.
// - Overflow FFFF to 0 sets flag and requests interrupt if enabled.
// - Buffering only on channels 0 and 3, C/D buffer A/B.
//
// Register access over APB and the register addresses were left to the implementer.
`timescale 1ns/1ps
`include "tbcpp_defines.vh"
module tbcpp_timer (
   // Clock and reset
   input wire core_clk_i,
   input wire rst_i,
   // APB slave
   input wire psel_i,
   input wire penable_i,
   input wire pwrite_i,
   input wire [7:0] paddr_i,
   input wire [31:0] pwdata_i,
   output reg [31:0] prdata_o,
   output reg pready_o,
   output reg pslverr_o,
   // Capture/compare pins, four per channel (A..D)
   input wire [23:0] capture_compare_pin_in_i,
   output reg [23:0] capture_compare_pin_out_o,
   output reg [23:0] capture_compare_pin_oe_o,
   // Encoder clock inputs
   input wire ext_clock_a_i,
   input wire ext_clock_b_i,
   input wire ext_clock_c_i,
   input wire ext_clock_d_i,
   // Per-channel interrupt requests
   output reg [5:0] timer_req_o
);

////////////////////////////////////////////////////////////////////////////////
function has_cd;
   input integer ch;
   begin
      has_cd = (ch == 0) || (ch == 3);
   end
endfunction

function phase_ok;
   input integer ch;
   begin
      phase_ok = (ch == 1) || (ch == 2) || (ch == 4) || (ch == 5);
   end
endfunction

function apply_act;
   input cur;
   input [1:0] act;
   begin
      case (act)
         `TBCPP_ACT_LOW: apply_act = 1'b0;
         `TBCPP_ACT_HIGH: apply_act = 1'b1;
         `TBCPP_ACT_TOGGLE: apply_act = ~cur;
         default: apply_act = cur;
      endcase
   end
endfunction

////////////////////////////////////////////////////////////////////////////////
reg [10:0] ctrl_reg [0:5];
reg [15:0] io_reg [0:5];
reg [5:0] ier_reg [0:5];
reg [5:0] stat_reg [0:5];
reg [5:0] dir_reg;
reg [15:0] cnt_reg [0:5];
reg [15:0] gr_reg [0:23];
reg [1:0] presc_reg;
reg [3:0] ext_prev_reg;
reg [23:0] pin_prev_reg;

reg inc_w [0:5];
reg dec_w [0:5];
reg ovf_w [0:5];
reg unf_w [0:5];
reg clr_w [0:5];
reg [3:0] hit_w [0:5];
reg [3:0] cap_w [0:5];

reg [1:0] csel;
reg [2:0] mode;
reg [2:0] clr_sel;
reg qa;
reg qb;
reg qa_p;
reg qb_p;
reg q_up;
reg q_dn;
reg tick;
reg pin_now;
reg pin_was;
reg [3:0] io_n;
integer c;
integer r;

wire [3:0] ext_now;
wire presc_tick;
wire [2:0] a_ch;
wire [2:0] a_ofs;
wire a_bad;
wire apb_wr;

assign ext_now = {ext_clock_d_i, ext_clock_c_i, ext_clock_b_i, ext_clock_a_i};
assign presc_tick = (presc_reg == `TBCPP_PRESC_LAST);
assign a_ch = paddr_i[7:5];
assign a_ofs = paddr_i[4:2];
assign a_bad = (a_ch > 3'h5) || (paddr_i[1:0] != 2'h0);
// Write lands on the edge where pready is seen high
assign apb_wr = psel_i & penable_i & pready_o & pwrite_i & ~a_bad;

////////////////////////////////////////////////////////////////////////////////
// Count events; loop runs high to low so lower halves resolve first
always @* begin
   csel = 2'h0;
   mode = 3'h0;
   clr_sel = 3'h0;
   qa = 1'b0;
   qb = 1'b0;
   qa_p = 1'b0;
   qb_p = 1'b0;
   q_up = 1'b0;
   q_dn = 1'b0;
   tick = 1'b0;
   pin_now = 1'b0;
   pin_was = 1'b0;
   io_n = 4'h0;
   for (c = 5; c >= 0; c = c - 1) begin
      csel = ctrl_reg[c][`TBCPP_CTRL_CSEL_LSB +: 2];
      mode = ctrl_reg[c][`TBCPP_CTRL_MODE_LSB +: 3];
      clr_sel = ctrl_reg[c][`TBCPP_CTRL_CLR_LSB +: 3];
      qa = (c == 1 || c == 5) ? ext_now[0] : ext_now[2];
      qb = (c == 1 || c == 5) ? ext_now[1] : ext_now[3];
      qa_p = (c == 1 || c == 5) ? ext_prev_reg[0] : ext_prev_reg[2];
      qb_p = (c == 1 || c == 5) ? ext_prev_reg[1] : ext_prev_reg[3];
      q_up = (qa & ~qa_p & ~qb) | (~qa & qa_p & qb) | (qb & ~qb_p & qa) | (~qb & qb_p & ~qa);
      q_dn = (qa & ~qa_p & qb) | (~qa & qa_p & ~qb) | (qb & ~qb_p & ~qa) | (~qb & qb_p & qa);
      inc_w[c] = 1'b0;
      dec_w[c] = 1'b0;
      if (ctrl_reg[c][`TBCPP_CTRL_START_BIT]) begin
         if (mode == `TBCPP_MODE_PHASE && phase_ok(c)) begin
            // Prescaler and edge choice play no part here
            inc_w[c] = q_up;
            dec_w[c] = q_dn;
         end else if (csel == `TBCPP_CSEL_CASC && (c == 1 || c == 4)) begin
            inc_w[c] = ovf_w[c + 1];
            dec_w[c] = unf_w[c + 1];
         end else if (csel == `TBCPP_CSEL_DIV4) begin
            inc_w[c] = presc_tick;
         end else if (csel == `TBCPP_CSEL_EXTA) begin
            inc_w[c] = ext_now[0] & ~ext_prev_reg[0];
         end else begin
            inc_w[c] = 1'b1;
         end
      end
      tick = inc_w[c] | dec_w[c];
      ovf_w[c] = inc_w[c] && (cnt_reg[c] == `TBCPP_CNT_MAX);
      // Down counts only come from phase inputs, directly or by cascade
      unf_w[c] = dec_w[c] && (cnt_reg[c] == 16'h0000);
      for (r = 0; r < 4; r = r + 1) begin
         io_n = io_reg[c][r * 4 +: 4];
         pin_now = capture_compare_pin_in_i[c * 4 + r];
         pin_was = pin_prev_reg[c * 4 + r];
         hit_w[c][r] = (r < 2 || has_cd(c)) && !io_n[`TBCPP_IO_CAP_BIT] && tick
            && (cnt_reg[c] == gr_reg[c * 4 + r]);
         cap_w[c][r] = (r < 2 || has_cd(c)) && io_n[`TBCPP_IO_CAP_BIT]
            && ((io_n[0] & pin_now & ~pin_was) | (io_n[1] & ~pin_now & pin_was));
      end
      clr_w[c] = (clr_sel != 3'h0) && (hit_w[c][clr_sel[1:0] - 2'h1] | cap_w[c][clr_sel[1:0] - 2'h1]);
   end
end

////////////////////////////////////////////////////////////////////////////////
// Channel state, pins and registers
reg [15:0] rd_val;
integer k;
integer m;

always @* begin
   rd_val = 16'h0000;
   case (a_ofs)
      `TBCPP_OFS_CTRL: rd_val = {5'h00, ctrl_reg[a_ch]};
      `TBCPP_OFS_IO: rd_val = io_reg[a_ch];
      `TBCPP_OFS_IER: rd_val = {10'h000, ier_reg[a_ch]};
      `TBCPP_OFS_STAT: rd_val = {9'h000, dir_reg[a_ch], stat_reg[a_ch]};
      `TBCPP_OFS_CNT: rd_val = cnt_reg[a_ch];
      `TBCPP_OFS_GRA: rd_val = gr_reg[a_ch * 4];
      `TBCPP_OFS_GRB: rd_val = gr_reg[a_ch * 4 + 1];
      default: rd_val = has_cd(a_ch) ? gr_reg[a_ch * 4 + 2] : 16'h0000;
   endcase
end

// Register D has no read path; it is loaded through the upper half of the C word
always @(posedge core_clk_i or posedge rst_i) begin
   if (rst_i) begin
      for (k = 0; k < 6; k = k + 1) begin
         ctrl_reg[k] <= `TBCPP_CTRL_RESET;
         io_reg[k] <= `TBCPP_IO_RESET;
         ier_reg[k] <= `TBCPP_IER_RESET;
         stat_reg[k] <= 6'h00;
         cnt_reg[k] <= 16'h0000;
      end
      for (k = 0; k < 24; k = k + 1) begin
         gr_reg[k] <= 16'hFFFF;
      end
      dir_reg <= 6'h3F;
      presc_reg <= 2'h0;
      ext_prev_reg <= 4'h0;
      pin_prev_reg <= 24'h000000;
      capture_compare_pin_out_o <= 24'h000000;
      capture_compare_pin_oe_o <= 24'h000000;
      timer_req_o <= 6'h00;
      prdata_o <= 32'h00000000;
      pready_o <= 1'b0;
      pslverr_o <= 1'b0;
   end else begin
      presc_reg <= presc_reg + 2'h1;
      ext_prev_reg <= ext_now;
      pin_prev_reg <= capture_compare_pin_in_i;
      // One wait state so read data comes from a flop
      pready_o <= psel_i & penable_i & ~pready_o;
      if (psel_i & penable_i & ~pready_o) begin
         prdata_o <= a_bad ? 32'h00000000 : {16'h0000, rd_val};
         pslverr_o <= a_bad;
      end
      for (k = 0; k < 6; k = k + 1) begin
         // Software writes first; same-cycle hardware events override below
         if (apb_wr && a_ch == k) begin
            case (a_ofs)
               `TBCPP_OFS_CTRL: ctrl_reg[k] <= pwdata_i[10:0];
               `TBCPP_OFS_IO: io_reg[k] <= pwdata_i[15:0];
               `TBCPP_OFS_IER: ier_reg[k] <= pwdata_i[5:0];
               `TBCPP_OFS_GRA: gr_reg[k * 4] <= pwdata_i[15:0];
               `TBCPP_OFS_GRB: gr_reg[k * 4 + 1] <= pwdata_i[15:0];
               `TBCPP_OFS_GRC: begin
                  if (has_cd(k)) begin
                     gr_reg[k * 4 + 2] <= pwdata_i[15:0];
                     gr_reg[k * 4 + 3] <= pwdata_i[31:16];
                  end
               end
               default: ;
            endcase
         end
         // Counter: software write, then clear, then count
         if (apb_wr && a_ch == k && a_ofs == `TBCPP_OFS_CNT) begin
            cnt_reg[k] <= pwdata_i[15:0];
         end else if (clr_w[k]) begin
            cnt_reg[k] <= 16'h0000;
         end else if (inc_w[k]) begin
            cnt_reg[k] <= cnt_reg[k] + 16'h0001;
         end else if (dec_w[k]) begin
            cnt_reg[k] <= cnt_reg[k] - 16'h0001;
         end
         if (inc_w[k]) begin
            dir_reg[k] <= 1'b1;
         end else if (dec_w[k]) begin
            dir_reg[k] <= 1'b0;
         end
         // Flags: set wins over write-one-to-clear
         stat_reg[k] <= (stat_reg[k] & ~((apb_wr && a_ch == k && a_ofs == `TBCPP_OFS_STAT) ? pwdata_i[5:0] : 6'h00))
            | {unf_w[k], ovf_w[k], hit_w[k] | cap_w[k]};
         timer_req_o[k] <= |(stat_reg[k] & ier_reg[k]);
         // Own loop index: the event logic above owns r
         for (m = 0; m < 4; m = m + 1) begin
            if (cap_w[k][m]) begin
               // Cascaded halves capture their own counters in the same edge
               gr_reg[k * 4 + m] <= cnt_reg[k];
               if (m < 2 && has_cd(k) && ctrl_reg[k][`TBCPP_CTRL_BUFA_BIT + m]) begin
                  gr_reg[k * 4 + m + 2] <= gr_reg[k * 4 + m];
               end
            end
            if (hit_w[k][m] && m < 2 && has_cd(k) && ctrl_reg[k][`TBCPP_CTRL_BUFA_BIT + m]) begin
               gr_reg[k * 4 + m] <= gr_reg[k * 4 + m + 2];
            end
         end
         pin_update(k);
      end
   end
end

////////////////////////////////////////////////////////////////////////////////
// Pin drive per channel mode
task pin_update;
   input integer ch;
   reg [2:0] md;
   reg [2:0] cs;
   reg [15:0] io;
   integer p;
   integer q;
   integer base;
   begin
      md = ctrl_reg[ch][`TBCPP_CTRL_MODE_LSB +: 3];
      cs = ctrl_reg[ch][`TBCPP_CTRL_CLR_LSB +: 3];
      io = io_reg[ch];
      base = ch * 4;
      for (p = 0; p < 4; p = p + 1) begin
         q = (md == `TBCPP_MODE_PWM1) ? (p & 2) : p;
         if (!(p < 2 || has_cd(ch)) || io[p * 4 + `TBCPP_IO_CAP_BIT]) begin
            capture_compare_pin_oe_o[base + p] <= 1'b0;
         end else if (md == `TBCPP_MODE_PWM1) begin
            capture_compare_pin_oe_o[base + p] <= ((p & 1) == 0);
         end else if (md == `TBCPP_MODE_PWM2) begin
            capture_compare_pin_oe_o[base + p] <= !(cs != 3'h0 && p == cs - 3'h1);
         end else begin
            capture_compare_pin_oe_o[base + p] <= (io[p * 4 +: 2] != `TBCPP_ACT_NONE);
         end
         if (!ctrl_reg[ch][`TBCPP_CTRL_START_BIT]) begin
            capture_compare_pin_out_o[base + p] <= io[q * 4 + `TBCPP_IO_INIT_BIT];
         end else if (md == `TBCPP_MODE_PWM1) begin
            if ((p & 1) == 0 && gr_reg[base + p] != gr_reg[base + p + 1]) begin
               if (hit_w[ch][p + 1]) begin
                  capture_compare_pin_out_o[base + p] <= apply_act(capture_compare_pin_out_o[base + p],
                     io[(p + 1) * 4 +: 2]);
               end else if (hit_w[ch][p]) begin
                  capture_compare_pin_out_o[base + p] <= apply_act(capture_compare_pin_out_o[base + p],
                     io[p * 4 +: 2]);
               end
            end
         end else if (md == `TBCPP_MODE_PWM2) begin
            if (clr_w[ch]) begin
               capture_compare_pin_out_o[base + p] <= io[p * 4 + `TBCPP_IO_INIT_BIT];
            end else if (cs != 3'h0 && hit_w[ch][p]
               && gr_reg[base + p] != gr_reg[base + cs - 1]) begin
               capture_compare_pin_out_o[base + p] <= apply_act(capture_compare_pin_out_o[base + p],
                  io[p * 4 +: 2]);
            end
         end else if (hit_w[ch][p]) begin
            capture_compare_pin_out_o[base + p] <= apply_act(capture_compare_pin_out_o[base + p],
               io[p * 4 +: 2]);
         end
      end
   end
endtask

endmodule // tbcpp_timer

// File: common/tbcpp_defines.vh
`ifndef TBCPP_DEFINES_VH
`define TBCPP_DEFINES_VH
// Channel window: 8 words per channel
`define TBCPP_CH_STRIDE_SHIFT 5
`define TBCPP_NUM_CH 6
`define TBCPP_OFS_CTRL 3'h0
`define TBCPP_OFS_IO 3'h1
`define TBCPP_OFS_IER 3'h2
`define TBCPP_OFS_STAT 3'h3
`define TBCPP_OFS_CNT 3'h4
`define TBCPP_OFS_GRA 3'h5
`define TBCPP_OFS_GRB 3'h6
`define TBCPP_OFS_GRC 3'h7
// counter_control_reg fields
`define TBCPP_CTRL_CSEL_LSB 0
`define TBCPP_CTRL_CLR_LSB 2
`define TBCPP_CTRL_MODE_LSB 5
`define TBCPP_CTRL_BUFA_BIT 8
`define TBCPP_CTRL_BUFB_BIT 9
`define TBCPP_CTRL_START_BIT 10
`define TBCPP_CTRL_RESET 11'h000
// Clock select codes
`define TBCPP_CSEL_CORE 2'h0
`define TBCPP_CSEL_DIV4 2'h1
`define TBCPP_CSEL_CASC 2'h2
`define TBCPP_CSEL_EXTA 2'h3
// Mode codes
`define TBCPP_MODE_NORMAL 3'h0
`define TBCPP_MODE_PWM1 3'h1
`define TBCPP_MODE_PWM2 3'h2
`define TBCPP_MODE_PHASE 3'h3
// io_control_reg nibble per register: [1:0] action/edge, [2] initial, [3] capture
`define TBCPP_IO_INIT_BIT 2
`define TBCPP_IO_CAP_BIT 3
`define TBCPP_IO_RESET 16'h0000
// Output actions
`define TBCPP_ACT_NONE 2'h0
`define TBCPP_ACT_LOW 2'h1
`define TBCPP_ACT_HIGH 2'h2
`define TBCPP_ACT_TOGGLE 2'h3
// timer_status_reg bits
`define TBCPP_ST_OVF_BIT 4
`define TBCPP_ST_UNF_BIT 5
`define TBCPP_ST_DIR_BIT 6
`define TBCPP_IER_RESET 6'h00
`define TBCPP_CNT_MAX 16'hFFFF
`define TBCPP_PRESC_LAST 2'h3
`endif

// File: verif/tbcpp_checker.sv
`timescale 1ns/1ps
module tbcpp_checker (
   // Clock and reset
   input wire core_clk_i,
   input wire rst_i,
   // APB
   input wire psel_i,
   input wire penable_i,
   input wire pwrite_i,
   input wire [7:0] paddr_i,
   input wire [31:0] prdata_o,
   input wire pready_o,
   input wire pslverr_o
);
   default clocking @(posedge core_clk_i); endclocking
   default disable iff (rst_i);
   wire rd_done = pready_o && !pwrite_i;
   wire [2:0] ch = paddr_i[7:5];
   wire bad = ch > 3'h5 || paddr_i[1:0] != 2'h0;
   ////////////////////////////////////////
   sequence s_setup;
      psel_i && !penable_i;
   endsequence
   sequence s_answer;
      !pready_o ##1 pready_o;
   endsequence
   property p_wait;
      s_setup ##1 (psel_i && penable_i) |-> s_answer;
   endproperty
   a_wait: assert property (p_wait) else $error("ready not in second access cycle");
   property p_one;
      pready_o |=> !pready_o;
   endproperty
   a_one: assert property (p_one) else $error("ready held too long");
   property p_qual;
      pready_o |-> psel_i && penable_i;
   endproperty
   a_qual: assert property (p_qual) else $error("ready outside access");
   property p_bad;
      pready_o && bad |-> pslverr_o;
   endproperty
   a_bad: assert property (p_bad) else $error("bad address not refused");
   property p_good;
      pready_o && !bad |-> !pslverr_o;
   endproperty
   a_good: assert property (p_good) else $error("good address refused");
   property p_errz;
      rd_done && pslverr_o |-> prdata_o == 32'h0;
   endproperty
   a_errz: assert property (p_errz) else $error("refused read not zero");
   property p_cd;
      rd_done && paddr_i[4:2] == 3'h7 && ch != 3'h0 && ch != 3'h3 |-> prdata_o == 32'h0;
   endproperty
   a_cd: assert property (p_cd) else $error("absent buffer reads nonzero");
   property p_stat;
      rd_done && paddr_i[4:2] == 3'h3 |-> prdata_o[31:7] == 25'h0;
   endproperty
   a_stat: assert property (p_stat) else $error("status high bits set");
endmodule // tbcpp_checker

// File: verif/tbcpp_encoder.sv
`timescale 1ns/1ps
module tbcpp_encoder (
   // Clock
   input wire core_clk_i,
   // Quadrature lines
   output logic a_o,
   output logic b_o,
   output logic c_o,
   output logic d_o
);
   int s0 = 0;
   int s1 = 0;
   initial {a_o, b_o, c_o, d_o} = 4'h0;
   // Gray order: one line moves per step
   function automatic logic [1:0] gray(input int s);
      case (s & 3)
         0: return 2'b00;
         1: return 2'b10;
         2: return 2'b11;
         default: return 2'b01;
      endcase
   endfunction
   task automatic step(input logic up, input logic pair, input int n);
      repeat (n) begin
         repeat (4) @(posedge core_clk_i);
         if (pair) begin
            s1 += up ? 1 : -1;
            {c_o, d_o} <= gray(s1);
         end else begin
            s0 += up ? 1 : -1;
            {a_o, b_o} <= gray(s0);
         end
      end
      repeat (6) @(posedge core_clk_i);
   endtask
endmodule // tbcpp_encoder

// File: verif/testbench.sv
`timescale 1ns/1ps
module testbench;
   logic core_clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic psel_i = 1'b0;
   logic penable_i = 1'b0;
   logic pwrite_i = 1'b0;
   logic [7:0] paddr_i = 8'h00;
   logic [31:0] pwdata_i = 32'h0;
   logic [31:0] prdata_o;
   logic pready_o;
   logic pslverr_o;
   logic [23:0] pin_in = 24'h0;
   logic [23:0] pin_out;
   logic [23:0] pin_oe;
   logic [5:0] req;
   logic ea, eb, ec, ed;
   logic [31:0] v, e, w;
   int err_total = 0;
   int cmp_count = 0;
   int cyc = 0;
   always #12.5 core_clk_i = ~core_clk_i;
   tbcpp_timer dut (.core_clk_i, .rst_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i,
      .prdata_o, .pready_o, .pslverr_o, .capture_compare_pin_in_i(pin_in),
      .capture_compare_pin_out_o(pin_out), .capture_compare_pin_oe_o(pin_oe), .ext_clock_a_i(ea),
      .ext_clock_b_i(eb), .ext_clock_c_i(ec), .ext_clock_d_i(ed), .timer_req_o(req));
   tbcpp_encoder enc (.core_clk_i, .a_o(ea), .b_o(eb), .c_o(ec), .d_o(ed));
   ////////////////////////////////////////
   task automatic wrap_up();
      $display("comparisons %0d mismatches %0d", cmp_count, err_total);
      if (err_total == 0 && cmp_count > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         err_total++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic xfer(input logic wr_en, input logic [7:0] a, input logic [31:0] d);
      psel_i <= 1'b1;
      pwrite_i <= wr_en;
      paddr_i <= a;
      pwdata_i <= d;
      @(posedge core_clk_i);
      penable_i <= 1'b1;
      do @(posedge core_clk_i); while (pready_o !== 1'b1);
      v = prdata_o;
      e = {31'h0, pslverr_o};
      psel_i <= 1'b0;
      penable_i <= 1'b0;
      @(posedge core_clk_i);
   endtask
   task automatic wr(input logic [2:0] ch, input logic [2:0] o, input logic [31:0] d);
      xfer(1'b1, {ch, o, 2'b00}, d);
   endtask
   task automatic rd(input logic [2:0] ch, input logic [2:0] o, input logic [31:0] m, input logic [31:0] x);
      xfer(1'b0, {ch, o, 2'b00}, 32'h0);
      chk(v & m, x);
   endtask
   // Sample pin over many cycles: bit0 low seen, bit1 high seen
   task automatic watch(input int i, input logic [31:0] x);
      logic [1:0] s;
      s = 2'b00;
      repeat (40) begin
         @(posedge core_clk_i);
         s |= 2'b01 << pin_out[i];
      end
      chk({30'h0, s}, x);
   endtask
   ////////////////////////////////////////
   always @(posedge core_clk_i) begin
      cyc++;
      if (cyc == 5000) begin
         err_total++;
         wrap_up();
      end
   end
   initial begin
      repeat (20) @(posedge core_clk_i);
      rst_i <= 1'b0;
      @(posedge core_clk_i);
      rd(0, 5, '1, 32'hFFFF);
      rd(1, 3, 32'h70, 32'h40);
      xfer(1'b0, 8'hC0, 32'h0);
      chk(e, 1);
      xfer(1'b1, 8'h15, 32'h5);
      chk(e, 1);
      rd(0, 5, '1, 32'hFFFF);
      wr(1, 7, 32'h55);
      rd(1, 7, '1, 0);
      wr(0, 5, 5);
      wr(0, 7, 9);
      wr(0, 1, 2);
      wr(0, 4, 0);
      chk({31'h0, pin_out[0]}, 0);
      wr(0, 0, 32'h500);
      repeat (30) @(posedge core_clk_i);
      rd(0, 5, '1, 9);
      chk({31'h0, pin_out[0]}, 1);
      wr(3, 1, 9);
      wr(3, 0, 32'h500);
      pin_in[12] <= 1'b1;
      repeat (5) @(posedge core_clk_i);
      rd(3, 7, 32'hFFFF, 32'hFFFF);
      xfer(1'b0, 8'h74, 32'h0);
      w = v;
      pin_in[12] <= 1'b0;
      repeat (5) @(posedge core_clk_i);
      pin_in[12] <= 1'b1;
      repeat (5) @(posedge core_clk_i);
      rd(3, 7, 32'hFFFF, w);
      // Equal pair, both low actions: any action would show
      wr(4, 1, 32'h15);
      wr(4, 5, 8);
      wr(4, 6, 8);
      wr(4, 0, 32'h424);
      repeat (30) @(posedge core_clk_i);
      chk({31'h0, pin_out[16]}, 1);
      wr(4, 6, 3);
      wr(4, 1, 32'h25);
      watch(16, 3);
      wr(5, 1, 2);
      wr(5, 5, 3);
      wr(5, 6, 6);
      wr(5, 0, 32'h448);
      watch(20, 3);
      chk({30'h0, pin_oe[21:20]}, 1);
      // Duty equal to cycle: pin must stay at its low initial level
      wr(5, 5, 6);
      repeat (10) @(posedge core_clk_i);
      watch(20, 1);
      wr(2, 0, 32'h460);
      wr(1, 0, 32'h402);
      wr(2, 4, 32'hFFFE);
      wr(1, 4, 0);
      enc.step(1'b1, 1'b1, 3);
      rd(2, 4, '1, 1);
      rd(1, 4, '1, 1);
      rd(2, 3, 32'h70, 32'h50);
      // Request follows flag and enable one cycle late
      wr(2, 2, 32'h10);
      @(posedge core_clk_i);
      chk({31'h0, req[2]}, 1);
      wr(2, 3, 32'h10);
      @(posedge core_clk_i);
      chk({31'h0, req[2]}, 0);
      enc.step(1'b0, 1'b1, 3);
      rd(2, 4, '1, 32'hFFFE);
      rd(1, 4, '1, 0);
      rd(2, 3, 32'h70, 32'h20);
      // Both halves capture on one edge: upper 0, lower FFFE
      wr(1, 1, 9);
      wr(2, 1, 9);
      pin_in[4] <= 1'b1;
      pin_in[8] <= 1'b1;
      repeat (3) @(posedge core_clk_i);
      rd(1, 5, '1, 0);
      rd(2, 5, '1, 32'hFFFE);
      wr(1, 0, 32'h462);
      enc.step(1'b1, 1'b0, 2);
      rd(2, 4, '1, 32'hFFFE);
      enc.step(1'b1, 1'b1, 2);
      rd(1, 4, '1, 2);
      rd(2, 4, '1, 0);
      // External clock A rising edges: four steps hold exactly one rise
      wr(0, 0, 32'h403);
      wr(0, 4, 0);
      enc.step(1'b1, 1'b0, 4);
      rd(0, 4, '1, 1);
      rd(1, 4, '1, 6);
      // Divide-by-four clock: 42 counting edges give 10 or 11 ticks
      wr(0, 0, 32'h401);
      wr(0, 4, 0);
      repeat (40) @(posedge core_clk_i);
      xfer(1'b0, 8'h10, 32'h0);
      chk({31'h0, v >= 10 && v <= 11}, 1);
      wrap_up();
   end
endmodule // testbench
bind tbcpp_timer tbcpp_checker chk_i (.core_clk_i, .rst_i, .psel_i, .penable_i, .pwrite_i,
   .paddr_i, .prdata_o, .pready_o, .pslverr_o);
